// file: hdl/kii_defs.vh
// Constants for the key input interrupt detector
`ifndef KII_DEFS_VH
`define KII_DEFS_VH

`define KII_ADDR_W 22
`define KII_DATA_W 32
`define KII_NCH 10
`define KII_NREG 6

// Register indices; byte address is four times the index
`define KII_IDX_EN_HIGH 20'hFFF36
`define KII_IDX_EN_LOW 20'hFFF37
`define KII_IDX_CTRL 20'hFFF38
`define KII_IDX_STATUS 20'hFFF39
`define KII_IDX_MASK 20'hFFF3A
`define KII_IDX_PINS 20'hFFF3B

// One-hot select positions
`define KII_SEL_EN_HIGH 0
`define KII_SEL_EN_LOW 1
`define KII_SEL_CTRL 2
`define KII_SEL_STATUS 3
`define KII_SEL_MASK 4
`define KII_SEL_PINS 5

// Enable register write format
`define KII_WR_BITOP 31
`define KII_WR_BITVAL 8
`define KII_WR_BITIDX_HI 2
`define KII_EN_HIGH_W 2

// Field positions
`define KII_CTRL_EDGE 0
`define KII_STAT_REQ 0
`define KII_STAT_LEVEL 1
`define KII_MASK_REQ 0

// Reset values
`define KII_EN_RESET 8'h00
`define KII_CTRL_RESET 1'b0
`define KII_MASK_RESET 1'b1

`endif

// file: hdl/kii_sync.v
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module kii_sync #(
  parameter W = 10
) (
  // Clock and reset
  input wire CLK,
  input wire NRST,
  // Data
  input wire [W-1:0] D_ASYNC,
  output wire [W-1:0] Q_SYNC
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      // First stage feeds only the second stage
      always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= D_ASYNC[i];
          sync_q <= meta_q;
        end
      end
      assign Q_SYNC[i] = sync_q;
    end
  endgenerate

endmodule // kii_sync

// file: hdl/kii_apb.v
// APB address decode and phase strobes
`timescale 1ns/1ps
`include "kii_defs.vh"
module kii_apb (
  // APB request
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`KII_ADDR_W-1:0] PADDR,
  // Decoded strobes
  output wire SETUP,
  output wire ACC_WR,
  output wire ACC_RD,
  output wire [`KII_NREG-1:0] SEL,
  output wire UNMAPPED
);

  function [`KII_NREG-1:0] decode;
    input [`KII_ADDR_W-1:0] addr;
    begin
      decode = {`KII_NREG{1'b0}};
      if (addr[1:0] == 2'h0) begin
        decode[`KII_SEL_EN_HIGH] = (addr[`KII_ADDR_W-1:2] == `KII_IDX_EN_HIGH);
        decode[`KII_SEL_EN_LOW] = (addr[`KII_ADDR_W-1:2] == `KII_IDX_EN_LOW);
        decode[`KII_SEL_CTRL] = (addr[`KII_ADDR_W-1:2] == `KII_IDX_CTRL);
        decode[`KII_SEL_STATUS] = (addr[`KII_ADDR_W-1:2] == `KII_IDX_STATUS);
        decode[`KII_SEL_MASK] = (addr[`KII_ADDR_W-1:2] == `KII_IDX_MASK);
        decode[`KII_SEL_PINS] = (addr[`KII_ADDR_W-1:2] == `KII_IDX_PINS);
      end
    end
  endfunction

  assign SEL = decode(PADDR);
  assign UNMAPPED = ~|SEL;
  assign SETUP = PSEL & ~PENABLE;
  assign ACC_WR = PSEL & PENABLE & PWRITE;
  assign ACC_RD = PSEL & PENABLE & ~PWRITE;

endmodule // kii_apb

// file: hdl/kii_top.v
// Key input interrupt detector with APB register access
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "kii_defs.vh"
module kii_top (
  // Clock and reset
  input wire CLK,
  input wire NRST,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`KII_ADDR_W-1:0] PADDR,
  input wire [`KII_DATA_W-1:0] PWDATA,
  input wire [3:0] PSTRB,
  output wire PREADY,
  output wire [`KII_DATA_W-1:0] PRDATA,
  output wire PSLVERR,
  // Key inputs
  input wire [`KII_NCH-1:0] KEY_PINS,
  // Interrupt controller side
  input wire INT_ACK,
  output wire KEY_IRQ,
  output wire KEY_LEVEL,
  // Port pins left to general use
  output wire [`KII_NCH-1:0] GPIO_FREE
);

  // Decoded bus strobes
  wire setup;
  wire acc_wr;
  wire acc_rd;
  wire [`KII_NREG-1:0] sel;
  wire unmapped;

  // Synchronised pins
  wire [`KII_NCH-1:0] pins_sync;

  // Register state
  reg [7:0] en_low_q;
  reg [7:0] en_low_d;
  reg [`KII_EN_HIGH_W-1:0] en_high_q;
  reg [`KII_EN_HIGH_W-1:0] en_high_d;
  reg edge_sel_q;
  reg mask_q;
  reg req_q;
  reg req_d;
  reg level_q;
  reg [`KII_DATA_W-1:0] prdata_q;
  reg [`KII_DATA_W-1:0] prdata_d;
  reg pslverr_q;

  // Detection terms
  wire [`KII_NCH-1:0] enables;
  wire [`KII_NCH-1:0] active;
  wire level_d;
  wire level_rise;
  wire wr_en_low;
  wire wr_en_high;
  wire [7:0] en_high_wr;
  wire wr_ctrl;
  wire wr_mask;
  wire rd_status;

  // Byte write, or a single-bit write selected by the bit-op flag
  function [7:0] apply_write;
    input [7:0] old;
    input [`KII_DATA_W-1:0] wdata;
    reg [7:0] res;
    begin
      res = old;
      if (wdata[`KII_WR_BITOP]) begin
        res[wdata[`KII_WR_BITIDX_HI:0]] = wdata[`KII_WR_BITVAL];
      end else begin
        res = wdata[7:0];
      end
      apply_write = res;
    end
  endfunction

  kii_apb u_apb (
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .SETUP(setup),
    .ACC_WR(acc_wr),
    .ACC_RD(acc_rd),
    .SEL(sel),
    .UNMAPPED(unmapped)
  );

  // Key switches are asynchronous and bounce
  kii_sync #(
    .W(`KII_NCH)
  ) u_sync (
    .CLK(CLK),
    .NRST(NRST),
    .D_ASYNC(KEY_PINS),
    .Q_SYNC(pins_sync)
  );

  // Zero-wait slave; read data is latched in the setup cycle
  assign PREADY = 1'b1;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;

  // Byte lane 0 carries the low data byte; lane 3 carries the bit-op flag
  assign wr_en_low = acc_wr & sel[`KII_SEL_EN_LOW] & (PSTRB[0] | PWDATA[`KII_WR_BITOP]);
  assign wr_en_high = acc_wr & sel[`KII_SEL_EN_HIGH] & (PSTRB[0] | PWDATA[`KII_WR_BITOP]);
  assign wr_ctrl = acc_wr & sel[`KII_SEL_CTRL] & PSTRB[0];
  assign wr_mask = acc_wr & sel[`KII_SEL_MASK] & PSTRB[0];
  assign rd_status = acc_rd & sel[`KII_SEL_STATUS];

  always @* begin
    en_low_d = en_low_q;
    if (wr_en_low) begin
      en_low_d = apply_write(en_low_q, PWDATA);
    end
  end

  // Only two implemented bits; bit writes above them are dropped
  assign en_high_wr = apply_write({6'h00, en_high_q}, PWDATA);

  always @* begin
    en_high_d = en_high_q;
    if (wr_en_high) begin
      en_high_d = en_high_wr[`KII_EN_HIGH_W-1:0];
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      en_low_q <= `KII_EN_RESET;
      en_high_q <= 2'h0;
      edge_sel_q <= `KII_CTRL_RESET;
      mask_q <= `KII_MASK_RESET;
    end else begin
      en_low_q <= en_low_d;
      en_high_q <= en_high_d;
      if (wr_ctrl) begin
        edge_sel_q <= PWDATA[`KII_CTRL_EDGE];
      end
      if (wr_mask) begin
        mask_q <= PWDATA[`KII_MASK_REQ];
      end
    end
  end

  // Detection
  assign enables = {en_high_q, en_low_q};
  // Edge select 0 means low active, 1 means high active
  assign active = edge_sel_q ? pins_sync : ~pins_sync;
  assign level_d = |(active & enables);
  // Only a rise of the combined level fires, so a second pin cannot re-trigger
  assign level_rise = level_d & ~level_q;

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_d;
    end
  end

  // Pending request: a new event in the clearing cycle wins
  always @* begin
    req_d = req_q;
    if (INT_ACK | rd_status) begin
      req_d = 1'b0;
    end
    if (level_rise) begin
      req_d = 1'b1;
    end
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_d;
    end
  end

  // Mask starts set so enable-time spurious requests stay hidden
  assign KEY_IRQ = req_q & ~mask_q;
  assign KEY_LEVEL = level_q;
  assign GPIO_FREE = ~enables;

  // Read data mux
  always @* begin
    prdata_d = {`KII_DATA_W{1'b0}};
    case (1'b1)
      sel[`KII_SEL_EN_LOW]: begin
        prdata_d[7:0] = en_low_q;
      end
      sel[`KII_SEL_EN_HIGH]: begin
        prdata_d[`KII_EN_HIGH_W-1:0] = en_high_q;
      end
      sel[`KII_SEL_CTRL]: begin
        prdata_d[`KII_CTRL_EDGE] = edge_sel_q;
      end
      sel[`KII_SEL_STATUS]: begin
        prdata_d[`KII_STAT_REQ] = req_q;
        prdata_d[`KII_STAT_LEVEL] = level_q;
      end
      sel[`KII_SEL_MASK]: begin
        prdata_d[`KII_MASK_REQ] = mask_q;
      end
      sel[`KII_SEL_PINS]: begin
        prdata_d[`KII_NCH-1:0] = pins_sync;
      end
      default: begin
        prdata_d = {`KII_DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_q <= {`KII_DATA_W{1'b0}};
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= PWRITE ? {`KII_DATA_W{1'b0}} : prdata_d;
      pslverr_q <= unmapped;
    end
  end

endmodule // kii_top

// file: verification/kii_asserts.sv
// Port-level assertion checker for the key input interrupt detector
`timescale 1ns/1ps
`include "kii_defs.vh"
module kii_asserts (
  // Clock and reset
  input wire CLK,
  input wire NRST,
  // APB
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`KII_ADDR_W-1:0] PADDR,
  input wire PREADY,
  input wire [`KII_DATA_W-1:0] PRDATA,
  input wire PSLVERR,
  // Key side
  input wire INT_ACK,
  input wire KEY_IRQ,
  input wire KEY_LEVEL,
  input wire [`KII_NCH-1:0] GPIO_FREE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire rd_setup = PSEL && !PENABLE && !PWRITE;
  wire in_map = PADDR[1:0] == 2'h0 && PADDR >= {`KII_IDX_EN_HIGH, 2'h0} &&
    PADDR <= {`KII_IDX_PINS, 2'h0};
  property p_rdy; PSEL && PENABLE |-> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err; PSEL && !PENABLE && !in_map |=> PSLVERR; endproperty
  a_err: assert property (p_err) else $error("unmapped ok");
  property p_hi; rd_setup && PADDR == {`KII_IDX_EN_HIGH, 2'h0} |=> PRDATA[31:2] == 30'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("high bits set");
  property p_lo; rd_setup && PADDR == {`KII_IDX_EN_LOW, 2'h0} |=> PRDATA[31:8] == 24'h0;
  endproperty
  a_lo: assert property (p_lo) else $error("low bits set");
  property p_rst; $rose(NRST) |-> GPIO_FREE == 10'h3FF && !KEY_IRQ && !KEY_LEVEL; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_off; $past(GPIO_FREE) == 10'h3FF |-> !KEY_LEVEL; endproperty
  a_off: assert property (p_off) else $error("level while off");
  property p_ack; INT_ACK ##1 !$rose(KEY_LEVEL) |-> !KEY_IRQ; endproperty
  a_ack: assert property (p_ack) else $error("ack kept irq");
  property p_fell; $fell(KEY_IRQ) |-> $past(INT_ACK) || $past(PSEL && PENABLE); endproperty
  a_fell: assert property (p_fell) else $error("irq dropped");
endmodule // kii_asserts
bind kii_top kii_asserts u_chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .INT_ACK(INT_ACK), .KEY_IRQ(KEY_IRQ), .KEY_LEVEL(KEY_LEVEL), .GPIO_FREE(GPIO_FREE));

// file: verification/kii_keys.sv
// Key switch model with external pull-ups
`timescale 1ns/1ps
module kii_keys (
  // Wanted levels
  input wire [9:0] tgt,
  // Pins
  output logic [9:0] pins
);
  // Pull-ups hold released keys high; skew keeps edges off the clock
  initial pins = 10'h3FF;
  always @(tgt) pins <= #7 tgt;
endmodule // kii_keys

// file: verification/test_key_input_interrupt.sv
// Self-checking bench for the key input interrupt detector
`timescale 1ns/1ps
`include "kii_defs.vh"
module test_key_input_interrupt;
  localparam logic [21:0] AHI = {`KII_IDX_EN_HIGH, 2'h0};
  localparam logic [21:0] ALO = {`KII_IDX_EN_LOW, 2'h0};
  localparam logic [21:0] ACT = {`KII_IDX_CTRL, 2'h0};
  localparam logic [21:0] AST = {`KII_IDX_STATUS, 2'h0};
  localparam logic [21:0] AMK = {`KII_IDX_MASK, 2'h0};
  localparam logic [21:0] APN = {`KII_IDX_PINS, 2'h0};
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, ack = 0, rdy, err, e, irq, lvl;
  logic [21:0] pa = 0;
  logic [31:0] pw = 0, rd, prdata;
  logic [9:0] tgt = 10'h3FF, pins, free;
  logic [3:0] strb = 4'hF;
  int n_fail = 0, cmp_count = 0, k, j;
  initial forever #12.5 clk = ~clk;
  kii_keys u_keys (.tgt(tgt), .pins(pins));
  kii_top uut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pw), .PSTRB(strb), .PREADY(rdy), .PRDATA(prdata), .PSLVERR(err),
    .KEY_PINS(pins), .INT_ACK(ack), .KEY_IRQ(irq), .KEY_LEVEL(lvl), .GPIO_FREE(free));
  task chk(input logic [31:0] g, x, input string m);
    cmp_count++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [21:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pw <= d;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      final_report;
    end
    rd = prdata;
    e = err;
    psel <= 0;
    pen <= 0;
    // Idle cycle so no strobe is driven twice in one step
    @(posedge clk);
  endtask
  task wirq(input logic x);
    int n;
    for (n = 0; n < 20 && irq !== x; n++) @(posedge clk);
    chk(irq, x, "irq level");
    if (irq !== x) final_report;
  endtask
  initial begin
    void'($urandom(32'h6b63954a));
    repeat (5) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    apb(0, AHI, 0);
    chk(rd, 0, "hi reset");
    apb(0, ALO, 0);
    chk(rd, 0, "lo reset");
    chk(free, 10'h3FF, "free reset");
    apb(0, 22'h000010, 0);
    chk(e, 1, "unmapped");
    for (j = 0; j < 4; j++) begin
      k = $urandom;
      apb(1, ALO, k & 8'hFF);
      apb(1, AHI, k >> 8 & 8'hFF);
      apb(0, ALO, 0);
      chk(rd, k & 8'hFF, "lo byte");
      apb(0, AHI, 0);
      chk(rd, k >> 8 & 3, "hi byte");
      chk(free, {22'h0, ~k[9:0]}, "free map");
    end
    apb(1, ALO, 0);
    apb(1, AHI, 0);
    k = $urandom % 8;
    apb(1, ALO, 32'h80000100 | k);
    apb(1, AHI, 32'h80000105);
    apb(0, ALO, 0);
    chk(rd, 1 << k, "bit set");
    apb(0, AHI, 0);
    chk(rd, 0, "hi bad index");
    strb <= 4'h0;
    apb(1, ALO, 32'hFF);
    strb <= 4'hF;
    apb(0, ALO, 0);
    chk(rd, 1 << k, "no strobe");
    apb(1, AMK, 0);
    tgt[k] <= 0;
    wirq(1);
    j = (k + 1) % 8;
    apb(1, ALO, 32'h80000100 | j);
    ack <= 1;
    @(posedge clk);
    ack <= 0;
    wirq(0);
    tgt[j] <= 0;
    repeat (6) @(posedge clk);
    chk(irq, 0, "retrigger");
    apb(0, APN, 0);
    chk(rd[9:0], tgt, "pin levels");
    tgt <= 10'h3FF;
    repeat (6) @(posedge clk);
    tgt[8] <= 0;
    repeat (6) @(posedge clk);
    chk(irq, 0, "disabled pin");
    apb(1, AHI, 1);
    wirq(1);
    apb(0, AST, 0);
    wirq(0);
    apb(1, AMK, 1);
    apb(1, AHI, 0);
    tgt[9] <= 0;
    repeat (6) @(posedge clk);
    apb(1, AHI, 3);
    repeat (6) @(posedge clk);
    apb(0, AST, 0);
    chk(rd[0], 1, "masked flag");
    apb(1, AMK, 0);
    chk(irq, 0, "masked enable");
    apb(1, ALO, 0);
    apb(1, AHI, 0);
    tgt <= 0;
    apb(1, ACT, 1);
    apb(1, ALO, 1 << k);
    tgt[k] <= 1;
    wirq(1);
    nrst <= 0;
    @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    apb(0, ALO, 0);
    chk(rd, 0, "lo mid reset");
    final_report;
  end
endmodule // test_key_input_interrupt
